// [rtl/rar_defs.svh]
/*
 * Constants of the reference-loss and fault auto-restart supervisor:
 * register offsets, field positions, reset values and timing figures.
 * Assumes it is included by bare name from the module and the bench.
 */
`ifndef RAR_DEFS_SVH
`define RAR_DEFS_SVH

// ==========================================================
// register byte offsets
`define RAR_OFF_CTRL 8'h00
`define RAR_OFF_RATIO 8'h04
`define RAR_OFF_OUTSEL 8'h08
`define RAR_OFF_STATUS 8'h0C
`define RAR_OFF_INT_STAT 8'h10
`define RAR_OFF_INT_MASK 8'h14
`define RAR_OFF_CMD 8'h18

// ==========================================================
// field positions
`define RAR_CTRL_LOSS_ACT 0
`define RAR_CTRL_CONTACT 1
`define RAR_CTRL_RIDE_LO 2
`define RAR_CTRL_LIMIT_LO 8
`define RAR_CMD_FAULT_RST 0
`define RAR_INT_LOSS 0
`define RAR_INT_RESTART 1
`define RAR_INT_TRIP 2
`define RAR_INT_CLEARED 3

// fault vector bit positions
`define RAR_FLT_UV 4

// ==========================================================
// reset values and codes
`define RAR_RST_CTRL 12'h000
`define RAR_RST_RATIO 10'h320
`define RAR_RATIO_FULL 10'h3E8
`define RAR_LIMIT_MAX 4'hA
`define RAR_RST_OUTSEL 24'h000000
`define RAR_CODE_REF_LOST 8'h0C
`define RAR_CODE_AUTO_RESTART 8'h1E
`define RAR_ELIG_MASK 14'h3FFF

// ==========================================================
// timing
`define RAR_CLK_MHZ 250
`define RAR_LOSS_WINDOW_MS 400
`define RAR_CLEAR_MINUTES 10
`define RAR_LOSS_WINDOW_CYC (`RAR_LOSS_WINDOW_MS * `RAR_CLK_MHZ * 1000)
`define RAR_CLEAR_CYC (64'd`RAR_CLEAR_MINUTES * 64'd60 * 64'd1000000 * 64'd`RAR_CLK_MHZ)

`endif

// [rtl/rar_pkg.sv]
/*
 * Types of the reference-loss and fault auto-restart supervisor.
 * Assumes rar_defs.svh for the numeric constants.
 */
package rar_pkg;
  // ==========================================================
  // restart sequencer states
  typedef enum logic [1:0] {
    ST_RUN,
    ST_DIAG,
    ST_SEARCH,
    ST_TRIP
  } rar_state_t;
endpackage : rar_pkg

// [rtl/rar_supervisor.sv]
/*
 * Supervisor for a motor drive: detects collapse of an analog speed
 * reference and substitutes a scaled fallback speed, and sequences
 * automatic restarts after transient faults. Registers sit on APB.
 * Assumes reference, run and fault inputs come from logic on ref_clk,
 * and that the fault-reset terminal is an asynchronous pin.
 */
`timescale 1ns/1ps
`include "rar_defs.svh"

// What this block does
// - flag loss when analog reference drops 90% or more within 400 ms.
// - with loss handling on and loss flagged, run at scaled pre-loss speed.
// - loss action 0 follows the reference, 1 uses fallback; default 0.
// - fallback is pre-loss speed times ratio 0.0-100.0 percent, default 80.0.
// - output terminal with selector code C asserts while reference loss flagged.
// - eligible fault while running triggers self-diagnosis, then automatic restart.
// - restart attempts limit programmable 0 to 10, default 0; 0 disables.
// - every restart begins with speed search from the pre-fault run speed.
// - only the listed transient faults are restart eligible.
// - any other fault trips protection with no restart attempt.
// - bus undervoltage is eligible only when ride-through select is 1 or 2.
// - output terminal with selector code 1E shows restart in progress.
// - contact select 0 keeps fault contact off during restart, 1 activates it.
// - counter clears after 10 minutes of fault-free running after a restart.
// - counter clears when a trip is acknowledged by an external fault reset.
// - counter clears on power-on reset.
module rar_supervisor
  import rar_pkg::*;
#(
  parameter int unsigned LOSS_WINDOW_CYC = `RAR_LOSS_WINDOW_CYC,
  parameter logic [39:0] CLEAR_CYC = 40'(`RAR_CLEAR_CYC),
  parameter int unsigned REF_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // speed reference
  input wire logic [REF_W-1:0] refIn,
  input wire logic refIsAnalog,
  output logic [REF_W-1:0] speedCmd,
  // drive status and faults
  input wire logic running,
  input wire logic [13:0] faultVec,
  input wire logic otherFault,
  input wire logic faultResetPin,
  // diagnosis and speed search engine
  input wire logic diagDone,
  input wire logic diagError,
  input wire logic searchDone,
  output logic searchStart,
  output logic [REF_W-1:0] searchFreq,
  // status outputs
  output logic restartActive,
  output logic faultContact,
  output logic protectTrip,
  output logic [2:0] terminalOut,
  output logic irq
);

  // ==========================================================
  // apb slave and registers
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [11:0] ctrl_r, ctrl_nxt;
  logic [9:0] ratio_r, ratio_nxt;
  logic [23:0] outSel_r, outSel_nxt;
  logic [3:0] intStat_r, intStat_nxt;
  logic [3:0] intMask_r, intMask_nxt;
  logic irq_r, irq_nxt;
  logic cmdReset;
  logic doWrite, doAccess, mapped;
  logic [31:0] rdVal;
  logic [3:0] events;

  // loss detection state
  logic [31:0] winCnt_r, winCnt_nxt;
  logic [REF_W-1:0] base_r, base_nxt;
  logic lossFlag_r, lossFlag_nxt;
  logic [REF_W-1:0] speedCmd_r, speedCmd_nxt;
  logic [REF_W+3:0] refTimes10, baseWide;
  logic [REF_W+9:0] fallProd;
  logic [9:0] ratioEff;
  logic lossSet;

  // restart sequencer state
  rar_state_t state_r, state_nxt;
  logic [3:0] count_r, count_nxt;
  logic [39:0] timer_r, timer_nxt;
  logic [REF_W-1:0] searchFreq_r, searchFreq_nxt;
  logic searchStart_r, searchStart_nxt;
  logic evRestart, evTrip, evCleared;
  logic anyFault, eligible;
  logic [3:0] limitEff;
  logic [1:0] rideSel;

  // output staging
  logic restartActive_r, restartActive_nxt;
  logic faultContact_r, faultContact_nxt;
  logic protectTrip_r, protectTrip_nxt;
  logic [2:0] termOut_r, termOut_nxt;

  // fault-reset pin synchroniser
  logic rstPinMeta_r, rstPinSync_r;

  // one wait state: prdata and pready come from flops
  assign doAccess = psel && penable && pready_r;
  assign doWrite = doAccess && pwrite;
  assign cmdReset = doWrite && (paddr == `RAR_OFF_CMD) && pwdata[`RAR_CMD_FAULT_RST];

  always_comb begin
    mapped = 1'b1;
    rdVal = 32'h00000000;
    case (paddr)
      `RAR_OFF_CTRL: rdVal = {20'h00000, ctrl_r};
      `RAR_OFF_RATIO: rdVal = {22'h000000, ratio_r};
      `RAR_OFF_OUTSEL: rdVal = {8'h00, outSel_r};
      `RAR_OFF_STATUS: begin
        rdVal = {speedCmd_r, 8'h00, count_r, 1'b0, protectTrip_r, restartActive_r,
                 lossFlag_r};
      end
      `RAR_OFF_INT_STAT: rdVal = {28'h0000000, intStat_r};
      `RAR_OFF_INT_MASK: rdVal = {28'h0000000, intMask_r};
      `RAR_OFF_CMD: rdVal = 32'h00000000;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    pready_nxt = psel && penable && !pready_r;
    prdata_nxt = pready_nxt ? rdVal : 32'h00000000;
    pslverr_nxt = pready_nxt && !mapped;
    ctrl_nxt = ctrl_r;
    ratio_nxt = ratio_r;
    outSel_nxt = outSel_r;
    intMask_nxt = intMask_r;
    if (doWrite) begin
      case (paddr)
        `RAR_OFF_CTRL: ctrl_nxt = pwdata[11:0];
        `RAR_OFF_RATIO: ratio_nxt = pwdata[9:0];
        `RAR_OFF_OUTSEL: outSel_nxt = pwdata[23:0];
        `RAR_OFF_INT_MASK: intMask_nxt = pwdata[3:0];
        default: ;
      endcase
    end
    // a new event wins over a write-one clear in the same cycle
    intStat_nxt = intStat_r;
    if (doWrite && paddr == `RAR_OFF_INT_STAT) begin
      intStat_nxt = intStat_r & ~pwdata[3:0];
    end
    intStat_nxt = intStat_nxt | events;
    irq_nxt = |(intStat_nxt & intMask_nxt);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      ctrl_r <= `RAR_RST_CTRL;
      ratio_r <= `RAR_RST_RATIO;
      outSel_r <= `RAR_RST_OUTSEL;
      intStat_r <= 4'h0;
      intMask_r <= 4'h0;
      irq_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      ctrl_r <= ctrl_nxt;
      ratio_r <= ratio_nxt;
      outSel_r <= outSel_nxt;
      intStat_r <= intStat_nxt;
      intMask_r <= intMask_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ==========================================================
  // reference loss detection and fallback speed
  // a sample of the reference is taken at each window start; a
  // collapse to a tenth or less of that sample inside the window is a loss
  assign refTimes10 = {refIn, 4'h0} - {3'b000, refIn, 1'b0} - {3'b000, refIn, 1'b0}
                      - {3'b000, refIn, 1'b0};
  assign baseWide = {4'h0, base_r};
  assign lossSet = refIsAnalog && (base_r != '0) && (refTimes10 <= baseWide);
  // ratio in tenths of a percent, held to the full-scale value
  assign ratioEff = (ratio_r > `RAR_RATIO_FULL) ? `RAR_RATIO_FULL : ratio_r;
  assign fallProd = base_r * ratioEff;

  always_comb begin
    winCnt_nxt = winCnt_r + 32'h00000001;
    base_nxt = base_r;
    lossFlag_nxt = lossFlag_r;
    if (winCnt_r >= LOSS_WINDOW_CYC - 1) begin
      winCnt_nxt = 32'h00000000;
      // base freezes during loss so it keeps the pre-loss speed
      if (!lossFlag_r && !lossSet) begin
        base_nxt = refIn;
      end
    end
    if (!lossFlag_r && lossSet) begin
      lossFlag_nxt = 1'b1;
    end else if (lossFlag_r && (!refIsAnalog || refTimes10 > baseWide)) begin
      lossFlag_nxt = 1'b0;
      base_nxt = refIn;
      winCnt_nxt = 32'h00000000;
    end
    // action 0 follows the collapsed reference, 1 holds the fallback
    if (ctrl_r[`RAR_CTRL_LOSS_ACT] && lossFlag_r) begin
      speedCmd_nxt = REF_W'(fallProd / 26'd1000);
    end else begin
      speedCmd_nxt = refIn;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      winCnt_r <= 32'h00000000;
      base_r <= '0;
      lossFlag_r <= 1'b0;
      speedCmd_r <= '0;
    end else begin
      winCnt_r <= winCnt_nxt;
      base_r <= base_nxt;
      lossFlag_r <= lossFlag_nxt;
      speedCmd_r <= speedCmd_nxt;
    end
  end

  // ==========================================================
  // fault-reset terminal synchroniser
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rstPinMeta_r <= 1'b0;
      rstPinSync_r <= 1'b0;
    end else begin
      rstPinMeta_r <= faultResetPin;
      rstPinSync_r <= rstPinMeta_r;
    end
  end

  // ==========================================================
  // auto-restart sequencer
  assign rideSel = ctrl_r[`RAR_CTRL_RIDE_LO +: 2];
  assign limitEff = (ctrl_r[`RAR_CTRL_LIMIT_LO +: 4] > `RAR_LIMIT_MAX) ? `RAR_LIMIT_MAX
                    : ctrl_r[`RAR_CTRL_LIMIT_LO +: 4];
  assign anyFault = (|faultVec) || otherFault;

  always_comb begin
    logic [13:0] eligMask;
    eligMask = `RAR_ELIG_MASK;
    // undervoltage qualifies only with ride-through enabled
    if (rideSel != 2'b01 && rideSel != 2'b10) begin
      eligMask[`RAR_FLT_UV] = 1'b0;
    end
    eligible = (|faultVec) && !otherFault && ((faultVec & ~eligMask) == 14'h0000);
  end

  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    timer_nxt = 40'h0000000000;
    searchFreq_nxt = searchFreq_r;
    searchStart_nxt = 1'b0;
    evRestart = 1'b0;
    evTrip = 1'b0;
    evCleared = 1'b0;
    case (state_r)
      ST_RUN, ST_SEARCH: begin
        if (anyFault && (running || state_r == ST_SEARCH)) begin
          if (eligible && limitEff != 4'h0 && count_r < limitEff) begin
            state_nxt = ST_DIAG;
            count_nxt = count_r + 4'h1;
            // remember the speed the drive ran at when the fault hit
            if (state_r == ST_RUN) begin
              searchFreq_nxt = speedCmd_r;
            end
            evRestart = 1'b1;
          end else begin
            state_nxt = ST_TRIP;
            evTrip = 1'b1;
          end
        end else if (state_r == ST_SEARCH) begin
          if (searchDone) begin
            state_nxt = ST_RUN;
          end
        end else if (running && count_r != 4'h0) begin
          // fault-free running time since the last restart
          if (timer_r >= CLEAR_CYC - 40'h0000000001) begin
            count_nxt = 4'h0;
            evCleared = 1'b1;
          end else begin
            timer_nxt = timer_r + 40'h0000000001;
          end
        end
      end
      ST_DIAG: begin
        if (diagDone) begin
          if (diagError) begin
            state_nxt = ST_TRIP;
            evTrip = 1'b1;
          end else begin
            state_nxt = ST_SEARCH;
            searchStart_nxt = 1'b1;
          end
        end
      end
      ST_TRIP: begin
        // faults must be gone before a reset is accepted
        if ((rstPinSync_r || cmdReset) && !anyFault) begin
          state_nxt = ST_RUN;
          count_nxt = 4'h0;
          evCleared = 1'b1;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
    restartActive_nxt = (state_nxt == ST_DIAG) || (state_nxt == ST_SEARCH);
    protectTrip_nxt = (state_nxt == ST_TRIP);
    faultContact_nxt = protectTrip_nxt
                       || (restartActive_nxt && ctrl_r[`RAR_CTRL_CONTACT]);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
      count_r <= 4'h0;
      timer_r <= 40'h0000000000;
      searchFreq_r <= '0;
      searchStart_r <= 1'b0;
      restartActive_r <= 1'b0;
      protectTrip_r <= 1'b0;
      faultContact_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      timer_r <= timer_nxt;
      searchFreq_r <= searchFreq_nxt;
      searchStart_r <= searchStart_nxt;
      restartActive_r <= restartActive_nxt;
      protectTrip_r <= protectTrip_nxt;
      faultContact_r <= faultContact_nxt;
    end
  end

  assign events = {evCleared, evTrip, evRestart, lossSet && !lossFlag_r};

  // ==========================================================
  // multi-function output terminals
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : gTerm
      always_comb begin
        case (outSel_r[gi*8 +: 8])
          `RAR_CODE_REF_LOST: termOut_nxt[gi] = lossFlag_nxt;
          `RAR_CODE_AUTO_RESTART: termOut_nxt[gi] = restartActive_nxt;
          default: termOut_nxt[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      termOut_r <= 3'b000;
    end else begin
      termOut_r <= termOut_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign speedCmd = speedCmd_r;
  assign searchStart = searchStart_r;
  assign searchFreq = searchFreq_r;
  assign restartActive = restartActive_r;
  assign faultContact = faultContact_r;
  assign protectTrip = protectTrip_r;
  assign terminalOut = termOut_r;
  assign irq = irq_r;

endmodule : rar_supervisor

// [verif/rar_props.sv]
/* Checker of the restart supervisor, bound to its top ports.
   Assumes one clock domain with a synchronous active-low reset. */
`timescale 1ns/1ps
// ==========================================================
// checker
module rar_props
  import rar_pkg::*;
#(
  parameter int unsigned LOSS_WINDOW_CYC = 64,
  parameter logic [39:0] CLEAR_CYC = 40'h00000000C8,
  parameter int unsigned REF_W = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // reference path
  input wire logic [REF_W-1:0] refIn,
  input wire logic refIsAnalog,
  input wire logic [REF_W-1:0] speedCmd,
  // restart path
  input wire logic running,
  input wire logic [13:0] faultVec,
  input wire logic otherFault,
  input wire logic searchStart,
  input wire logic [REF_W-1:0] searchFreq,
  input wire logic restartActive,
  input wire logic faultContact,
  input wire logic protectTrip
);
  logic inRun;
  // run state is the only one showing neither restart nor trip
  assign inRun = !restartActive && !protectTrip;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_other_trips: assert property (inRun && running && otherFault |=> protectTrip)
    else $error("other fault did not trip");
  a_idle_stays: assert property (inRun && !running |=> inRun)
    else $error("left run state while stopped");
  a_restart_cause: assert property ($rose(restartActive) |-> $past(running) &&
    !$past(otherFault) && ($past(faultVec) != 14'h0000))
    else $error("restart without eligible fault");
  a_freq_capture: assert property ($rose(restartActive) |->
    searchFreq == $past(speedCmd)) else $error("search frequency not captured");
  a_start_pulse: assert property (searchStart |=> !searchStart)
    else $error("search start longer than one cycle");
  a_start_active: assert property (searchStart |-> restartActive && !protectTrip)
    else $error("search start outside restart");
  a_trip_holds: assert property (protectTrip && (otherFault || |faultVec) |=> protectTrip)
    else $error("trip left with fault present");
  a_trip_contact: assert property (protectTrip |-> faultContact)
    else $error("fault contact off while tripped");
  a_ref_follow: assert property ($past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n) &&
    !$past(refIsAnalog, 2) && !$past(refIsAnalog) |-> speedCmd == $past(refIn))
    else $error("speed does not follow reference");
endmodule : rar_props

bind rar_supervisor rar_props #(.LOSS_WINDOW_CYC(LOSS_WINDOW_CYC), .CLEAR_CYC(CLEAR_CYC),
  .REF_W(REF_W)) u_props (.ref_clk(ref_clk), .rst_n(rst_n), .refIn(refIn),
  .refIsAnalog(refIsAnalog), .speedCmd(speedCmd), .running(running), .faultVec(faultVec),
  .otherFault(otherFault), .searchStart(searchStart), .searchFreq(searchFreq),
  .restartActive(restartActive), .faultContact(faultContact), .protectTrip(protectTrip));

// [verif/rar_drive_model.sv]
/* Model of the drive's diagnosis and speed-search engines.
   Assumes the supervisor's restart outputs share its clock. */
`timescale 1ns/1ps
// ==========================================================
// drive model
module rar_drive_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // supervisor outputs
  input wire logic restartActive,
  input wire logic searchStart,
  // bench controls
  input wire logic slowReply,
  input wire logic diagBad,
  // answers
  output logic diagDone,
  output logic diagError,
  output logic searchDone
);
  logic [1:0] mode_r;
  logic [3:0] cnt_r;
  // error line means nothing without diagDone, so it toggles meanwhile
  always_ff @(posedge ref_clk) begin
    diagDone <= 1'b0;
    searchDone <= 1'b0;
    diagError <= ~diagError;
    cnt_r <= cnt_r - 4'h1;
    if (!rst_n || !restartActive) begin
      mode_r <= 2'h0;
      diagError <= 1'b0;
    end else if (mode_r == 2'h0) begin
      mode_r <= 2'h1;
      cnt_r <= slowReply ? 4'hC : 4'h3;
    end else if (mode_r == 2'h1 && cnt_r == 4'h0) begin
      mode_r <= 2'h2;
      diagDone <= 1'b1;
      diagError <= diagBad;
    end else if (mode_r == 2'h2 && searchStart) begin
      mode_r <= 2'h3;
      cnt_r <= slowReply ? 4'hC : 4'h3;
    end else if (mode_r == 2'h3 && cnt_r == 4'h0) begin
      mode_r <= 2'h0;
      searchDone <= 1'b1;
    end
  end
endmodule : rar_drive_model

// [verif/rar_supervisor_test.sv]
/* Bench of the restart supervisor: APB, reference and fault stimulus.
   Assumes the drive model answers diagnosis and search requests. */
`timescale 1ns/1ps
`include "rar_defs.svh"
// ==========================================================
// bench top
module rar_supervisor_test
  import rar_pkg::*;
;
  localparam int WIN = 200;
  localparam int CLR = 200;
  logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] refIn = 16'h0000, speedCmd, searchFreq, base, rnd = 16'hC4C6;
  logic refIsAnalog = 1'b0, running = 1'b0, otherFault = 1'b0, faultResetPin = 1'b0;
  logic slowReply = 1'b0, diagBad = 1'b0, pready, pslverr, err, diagDone, diagError;
  logic searchDone, searchStart, restartActive, faultContact, protectTrip, irq;
  logic [13:0] faultVec = 14'h0000;
  logic [2:0] terminalOut;
  int failCount = 0, totalChecks = 0, cycles = 0, ratio;

  rar_supervisor #(.LOSS_WINDOW_CYC(WIN), .CLEAR_CYC(40'(CLR)), .REF_W(16)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .refIn(refIn), .refIsAnalog(refIsAnalog), .speedCmd(speedCmd), .running(running),
    .faultVec(faultVec), .otherFault(otherFault), .faultResetPin(faultResetPin),
    .diagDone(diagDone), .diagError(diagError), .searchDone(searchDone),
    .searchStart(searchStart), .searchFreq(searchFreq), .restartActive(restartActive),
    .faultContact(faultContact), .protectTrip(protectTrip), .terminalOut(terminalOut),
    .irq(irq));
  rar_drive_model u_model (.ref_clk(ref_clk), .rst_n(rst_n), .restartActive(restartActive),
    .searchStart(searchStart), .slowReply(slowReply), .diagBad(diagBad),
    .diagDone(diagDone), .diagError(diagError), .searchDone(searchDone));

  // ==========================================================
  // helpers
  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsrNext
  function automatic logic [15:0] fallback(input logic [15:0] b, input int r);
    return 16'((32'(b) * r) / 1000);
  endfunction : fallback
  task automatic finishTest();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finishTest
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // entered just after a rising edge; holds the request until pready is sampled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge ref_clk);
      n++;
    end
    check("apb ready", 32'(pready), 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, (a == `RAR_OFF_STATUS) ? (rd & 32'h000000F0) : rd, exp);
  endtask : rdChk
  task automatic faultPulse(input int idx, input logic oth);
    otherFault <= oth;
    faultVec <= oth ? 14'h0000 : 14'h0001 << idx;
    tick(2);
    otherFault <= 1'b0;
    faultVec <= 14'h0000;
    tick(1);
  endtask : faultPulse
  task automatic clearByPin();
    faultResetPin <= 1'b1;
    tick(5);
    faultResetPin <= 1'b0;
    tick(2);
  endtask : clearByPin
  task automatic waitIdle();
    int n;
    n = 0;
    while (restartActive !== 1'b0 && n < 100) begin
      tick(1);
      n++;
    end
    check("restart ends", 32'(restartActive), 32'h0);
  endtask : waitIdle

  // ==========================================================
  // clock, timeout and sequence
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      failCount++;
      finishTest();
    end
  end
  initial begin
    tick(5);
    rst_n <= 1'b1;
    tick(2);
    rdChk("ctrl reset", `RAR_OFF_CTRL, 32'h0);
    rdChk("ratio reset", `RAR_OFF_RATIO, 32'h320);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    apb(1'b1, `RAR_OFF_OUTSEL, 32'h001E0C);
    apb(1'b1, `RAR_OFF_CTRL, 32'h1);
    apb(1'b1, `RAR_OFF_INT_MASK, 32'h1);
    rnd = lfsrNext(rnd);
    base = 16'(1000 + rnd % 60000);
    refIsAnalog <= 1'b1;
    refIn <= base;
    tick(2 * WIN + 5);
    refIn <= base / 10;
    tick(3);
    check("loss out", 32'(terminalOut), 32'h1);
    check("fallback", 32'(speedCmd), 32'(fallback(base, 800)));
    check("loss irq", 32'(irq), 32'h1);
    for (int k = 0; k < 2; k++) begin
      rnd = lfsrNext(rnd);
      ratio = k ? 1000 : rnd % 1001;
      apb(1'b1, `RAR_OFF_RATIO, 32'(ratio));
      tick(2);
      check("ratio", 32'(speedCmd), 32'(fallback(base, ratio)));
    end
    apb(1'b1, `RAR_OFF_CTRL, 32'h0);
    tick(2);
    check("follow", 32'(speedCmd), 32'(base / 10));
    refIn <= base;
    tick(3);
    apb(1'b1, `RAR_OFF_INT_STAT, 32'hF);
    tick(1);
    check("irq clear", 32'(irq), 32'h0);
    refIn <= base / 10 + 16'h0001;
    tick(3);
    check("no loss", 32'(terminalOut), 32'h0);
    refIsAnalog <= 1'b0;
    refIn <= 16'h1234;
    running <= 1'b1;
    apb(1'b1, `RAR_OFF_INT_MASK, 32'h4);
    apb(1'b1, `RAR_OFF_CTRL, 32'h202);
    for (int i = 0; i < 14; i++) begin
      slowReply <= rnd[0];
      rnd = lfsrNext(rnd);
      faultPulse(i, 1'b0);
      if (i == `RAR_FLT_UV) begin
        check("uv trip", 32'(protectTrip), 32'h1);
        check("trip irq", 32'(irq), 32'h1);
        clearByPin();
        check("pin reset", 32'(protectTrip), 32'h0);
        apb(1'b1, `RAR_OFF_INT_STAT, 32'hF);
        apb(1'b1, `RAR_OFF_CTRL, rnd[1] ? 32'h206 : 32'h20A);
        faultPulse(i, 1'b0);
      end
      check("restart", {restartActive, faultContact, terminalOut[1], protectTrip},
        32'hE);
      check("freq", 32'(searchFreq), 32'h1234);
      rdChk("count one", `RAR_OFF_STATUS, 32'h10);
      waitIdle();
      check("irq masked", 32'(irq), 32'h0);
      tick(CLR + 30);
      rdChk("count clear", `RAR_OFF_STATUS, 32'h0);
    end
    apb(1'b1, `RAR_OFF_CTRL, 32'h204);
    for (int k = 0; k < 3; k++) begin
      faultPulse(k, 1'b0);
      check("limit", {restartActive, faultContact, protectTrip},
        k < 2 ? 32'h4 : 32'h3);
      waitIdle();
    end
    rdChk("count held", `RAR_OFF_STATUS, 32'h20);
    apb(1'b1, `RAR_OFF_CMD, 32'h1);
    tick(2);
    check("cmd reset", 32'(protectTrip), 32'h0);
    rdChk("count zero", `RAR_OFF_STATUS, 32'h0);
    for (int j = 0; j < 3; j++) begin
      apb(1'b1, `RAR_OFF_CTRL, j == 2 ? 32'h004 : 32'h204);
      diagBad <= (j == 1);
      faultPulse(j, j == 0);
      waitIdle();
      check("trip", {restartActive, protectTrip}, 32'h1);
      clearByPin();
    end
    diagBad <= 1'b0;
    apb(1'b1, `RAR_OFF_CTRL, 32'h204);
    faultPulse(5, 1'b0);
    waitIdle();
    rdChk("count before", `RAR_OFF_STATUS, 32'h10);
    rst_n <= 1'b0;
    tick(5);
    rst_n <= 1'b1;
    tick(2);
    rdChk("count por", `RAR_OFF_STATUS, 32'h0);
    finishTest();
  end
endmodule : rar_supervisor_test
